// *** src/tlec_regs.svh ***
`ifndef TLEC_REGS_SVH
`define TLEC_REGS_SVH

// register byte offsets on the APB slave
`define TLEC_OFF_STATUS   12'h000
`define TLEC_OFF_WAKE     12'h004
`define TLEC_OFF_SMASK    12'h008
`define TLEC_OFF_ASSIGN0  12'h010
`define TLEC_OFF_CMASK    12'h020
`define TLEC_OFF_LATCH    12'h024
`define TLEC_OFF_PEND     12'h028
`define TLEC_OFF_RAISE    12'h02C
`define TLEC_OFF_VEC0     12'h040
`define TLEC_OFF_VECEND   12'h080

// core event levels
`define TLEC_NLEV         16
`define TLEC_LVL_EMU      4'h0
`define TLEC_LVL_RESET    4'h1
`define TLEC_LVL_NMI      4'h2
`define TLEC_LVL_EXC      4'h3
`define TLEC_LVL_HWERR    4'h5
`define TLEC_LVL_TMR      4'h6
`define TLEC_LVL_GP_FIRST 4'h7
`define TLEC_LVL_GP_LAST  4'hF
`define TLEC_NGP          9

// assignment fields: four bits per source, eight sources per word
`define TLEC_ASG_W        4
`define TLEC_ASG_PER_WORD 8
`define TLEC_ASG_MAX      4'h8
`define TLEC_ASG_SPREAD   7

// reset values and fixed bits
`define TLEC_SMASK_RST    32'h0000_0000
`define TLEC_WAKE_RST     32'hFFFF_FFFF
`define TLEC_CMASK_RST    16'h0000
`define TLEC_CMASK_FIXED  16'h000F
`define TLEC_CMASK_RSVD   16'h0010
`define TLEC_VEC_RST      32'h0000_0000

`endif

// *** src/tlec_pkg.sv ***
package tlec_pkg;

	typedef enum logic [0:0] {
		TLEC_ST_IDLE  = 1'b0,
		TLEC_ST_OFFER = 1'b1
	} tlec_vec_st_t;

	typedef logic [15:0] tlec_lvl_vec_t;

endpackage

// *** src/tlec_sync.sv ***
`timescale 1ns/100ps
module tlec_sync #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
	logic [W-1:0] nxt_out;

	// a bit only moves once the last two stages agree, filtering one-cycle glitches
	always_comb begin
		nxt_out = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= i_async;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign o_sync = out_ff;
endmodule

// *** src/tlec_prio.sv ***
`timescale 1ns/100ps
module tlec_prio #(
	parameter int W = 16
) (
	input  wire logic [W-1:0]         i_vec,
	output logic                      o_any,
	output logic      [$clog2(W)-1:0] o_idx
);
	// lowest index wins: level numbers descend in priority
	always_comb begin
		o_any = 1'b0;
		o_idx = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (i_vec[i]) begin
				o_any = 1'b1;
				o_idx = ($clog2(W))'(i);
			end
		end
	end
endmodule

// *** src/tlec_top.sv ***
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "tlec_regs.svh"
module tlec_top
	import tlec_pkg::*;
#(
	parameter int NSRC = 32
) (
	input  wire logic            i_mclk,
	input  wire logic            i_rst_n,
	input  wire logic            i_psel,
	input  wire logic            i_penable,
	input  wire logic            i_pwrite,
	input  wire logic [11:0]     i_paddr,
	input  wire logic [31:0]     i_pwdata,
	output logic      [31:0]     o_prdata,
	output logic                 o_pready,
	output logic                 o_pslverr,
	input  wire logic [NSRC-1:0] i_periph_req,
	input  wire logic            i_emulation_req,
	input  wire logic            i_reset_event_req,
	input  wire logic            i_nonmaskable_req,
	input  wire logic            i_exception_req,
	input  wire logic            i_hardware_error_req,
	input  wire logic            i_core_timer_req,
	input  wire logic            i_core_idle,
	input  wire logic            i_vec_accept,
	input  wire logic            i_return_from_interrupt,
	output logic                 o_wakeup,
	output logic                 o_vec_valid,
	output logic      [3:0]      o_vec_level,
	output logic      [31:0]     o_vec_addr
);
	// NSRC must be a multiple of eight and at most 32
	localparam int ASGW = NSRC * `TLEC_ASG_W;
	localparam int NAW  = NSRC / `TLEC_ASG_PER_WORD;

	// default spreads sources over levels 7..13 so 14 and 15 stay free for software
	function automatic logic [ASGW-1:0] asg_default();
		logic [ASGW-1:0] v;
		v = '0;
		for (int i = 0; i < NSRC; i++) begin
			v[i*`TLEC_ASG_W +: `TLEC_ASG_W] = (`TLEC_ASG_W)'(i % `TLEC_ASG_SPREAD);
		end
		return v;
	endfunction
	localparam logic [ASGW-1:0] ASG_RST = asg_default();

	// out-of-range field values fall to the lowest level rather than vanish
	function automatic logic [3:0] src_level(input logic [3:0] f);
		return (f > `TLEC_ASG_MAX) ? `TLEC_LVL_GP_LAST : (`TLEC_LVL_GP_FIRST + f);
	endfunction

	logic [NSRC-1:0]     periph_s;
	logic                emu_s, rstev_s, nmi_s;
	logic [NSRC-1:0]     status_ff, nxt_status;
	logic [NSRC-1:0]     wake_ff, nxt_wake;
	logic [NSRC-1:0]     smask_ff, nxt_smask;
	logic [ASGW-1:0]     asg_ff, nxt_asg;
	tlec_lvl_vec_t       cmask_ff, nxt_cmask;
	logic [31:0]         vec_mem_ff [`TLEC_NLEV];
	logic [31:0]         nxt_vec_mem [`TLEC_NLEV];
	logic [31:0]         prdata_ff, nxt_prdata;
	logic                pready_ff, nxt_pready;
	logic                slverr_ff, nxt_slverr;
	logic [31:0]         rd_data;
	logic                hit, acc, wr, vec_wr;
	tlec_lvl_vec_t       sw_raise;
	tlec_lvl_vec_t       latch_ff, nxt_latch;
	tlec_lvl_vec_t       pend_ff, nxt_pend;
	tlec_lvl_vec_t       gp_req, req_vec, eff_mask, take_vec, ret_vec;
	tlec_vec_st_t        st_ff, nxt_st;
	logic                valid_ff, nxt_valid;
	logic [3:0]          level_ff, nxt_level;
	logic [31:0]         addr_ff, nxt_addr;
	logic                wake_out_ff, nxt_wake_out;
	logic                cand_any, cur_any, take;
	logic [3:0]          cand_idx, cur_idx;

	tlec_sync #(.W(NSRC + 3)) u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_async ({i_nonmaskable_req, i_reset_event_req, i_emulation_req, i_periph_req}),
		.o_sync  ({nmi_s, rstev_s, emu_s, periph_s})
	);

	tlec_prio #(.W(`TLEC_NLEV)) u_cand (
		.i_vec (latch_ff & eff_mask),
		.o_any (cand_any),
		.o_idx (cand_idx)
	);

	tlec_prio #(.W(`TLEC_NLEV)) u_cur (
		.i_vec (pend_ff),
		.o_any (cur_any),
		.o_idx (cur_idx)
	);

	// one wait state: read data is registered on the same edge that pready rises
	assign acc      = i_psel & i_penable;
	assign wr       = acc & i_pwrite & pready_ff & hit;
	assign vec_wr   = wr & (i_paddr >= `TLEC_OFF_VEC0) & (i_paddr < `TLEC_OFF_VECEND);
	assign eff_mask = (cmask_ff & ~`TLEC_CMASK_RSVD) | `TLEC_CMASK_FIXED;

	always_comb begin
		rd_data = '0;
		hit     = 1'b0;
		if (i_paddr == `TLEC_OFF_STATUS) begin
			hit                = 1'b1;
			rd_data[NSRC-1:0]  = status_ff;
		end else if (i_paddr == `TLEC_OFF_WAKE) begin
			hit                = 1'b1;
			rd_data[NSRC-1:0]  = wake_ff;
		end else if (i_paddr == `TLEC_OFF_SMASK) begin
			hit                = 1'b1;
			rd_data[NSRC-1:0]  = smask_ff;
		end else if (i_paddr == `TLEC_OFF_CMASK) begin
			hit                = 1'b1;
			rd_data[15:0]      = eff_mask;
		end else if (i_paddr == `TLEC_OFF_LATCH) begin
			hit                = 1'b1;
			rd_data[15:0]      = latch_ff;
		end else if (i_paddr == `TLEC_OFF_PEND) begin
			hit                = 1'b1;
			rd_data[15:0]      = pend_ff;
		end else if (i_paddr == `TLEC_OFF_RAISE) begin
			hit                = 1'b1;
		end else if ((i_paddr >= `TLEC_OFF_VEC0) && (i_paddr < `TLEC_OFF_VECEND)
			&& (i_paddr[1:0] == 2'h0)) begin
			hit                = 1'b1;
			rd_data            = vec_mem_ff[i_paddr[5:2]];
		end
		for (int w = 0; w < NAW; w++) begin
			if (i_paddr == (`TLEC_OFF_ASSIGN0 + 12'(w * 4))) begin
				hit     = 1'b1;
				rd_data = asg_ff[w*32 +: 32];
			end
		end
	end

	always_comb begin
		nxt_status  = periph_s;
		nxt_wake    = wake_ff;
		nxt_smask   = smask_ff;
		nxt_asg     = asg_ff;
		nxt_cmask   = cmask_ff;
		nxt_vec_mem = vec_mem_ff;
		sw_raise    = '0;
		nxt_pready  = acc & ~pready_ff;
		nxt_slverr  = acc & ~pready_ff & ~hit;
		nxt_prdata  = (acc & ~pready_ff) ? rd_data : prdata_ff;
		if (wr) begin
			if (i_paddr == `TLEC_OFF_WAKE) begin
				nxt_wake = i_pwdata[NSRC-1:0];
			end
			if (i_paddr == `TLEC_OFF_SMASK) begin
				nxt_smask = i_pwdata[NSRC-1:0];
			end
			if (i_paddr == `TLEC_OFF_CMASK) begin
				nxt_cmask = i_pwdata[15:0];
			end
			// software raise of a general-purpose level
			if ((i_paddr == `TLEC_OFF_RAISE) && (i_pwdata[3:0] >= `TLEC_LVL_GP_FIRST)) begin
				sw_raise[i_pwdata[3:0]] = 1'b1;
			end
			if (vec_wr) begin
				nxt_vec_mem[i_paddr[5:2]] = i_pwdata;
			end
			for (int w = 0; w < NAW; w++) begin
				if (i_paddr == (`TLEC_OFF_ASSIGN0 + 12'(w * 4))) begin
					nxt_asg[w*32 +: 32] = i_pwdata;
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			status_ff <= '0;
			wake_ff   <= NSRC'(`TLEC_WAKE_RST);
			smask_ff  <= NSRC'(`TLEC_SMASK_RST);
			asg_ff    <= ASG_RST;
			cmask_ff  <= `TLEC_CMASK_RST;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			slverr_ff <= 1'b0;
			for (int i = 0; i < `TLEC_NLEV; i++) begin
				vec_mem_ff[i] <= `TLEC_VEC_RST;
			end
		end else begin
			status_ff  <= nxt_status;
			wake_ff    <= nxt_wake;
			smask_ff   <= nxt_smask;
			asg_ff     <= nxt_asg;
			cmask_ff   <= nxt_cmask;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			slverr_ff  <= nxt_slverr;
			vec_mem_ff <= nxt_vec_mem;
		end
	end

	// shared levels are a plain OR; software sorts out who asked
	always_comb begin
		gp_req = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (status_ff[i] & smask_ff[i]) begin
				gp_req[src_level(asg_ff[i*`TLEC_ASG_W +: `TLEC_ASG_W])] = 1'b1;
			end
		end
	end

	// dedicated events skip the system stage entirely
	always_comb begin
		req_vec                  = gp_req;
		req_vec[`TLEC_LVL_EMU]   = emu_s;
		req_vec[`TLEC_LVL_RESET] = rstev_s;
		req_vec[`TLEC_LVL_NMI]   = nmi_s;
		req_vec[`TLEC_LVL_EXC]   = i_exception_req;
		req_vec[`TLEC_LVL_HWERR] = i_hardware_error_req;
		req_vec[`TLEC_LVL_TMR]   = i_core_timer_req;
	end

	assign take = valid_ff & i_vec_accept;

	always_comb begin
		take_vec = '0;
		ret_vec  = '0;
		if (take) begin
			take_vec[level_ff] = 1'b1;
		end
		if (i_return_from_interrupt & cur_any) begin
			ret_vec[cur_idx] = 1'b1;
		end
		// a level in service is not latched again until its return
		nxt_latch    = (latch_ff | ((req_vec | sw_raise) & ~pend_ff)) & ~take_vec;
		nxt_pend     = (pend_ff & ~ret_vec) | take_vec;
		nxt_wake_out = i_core_idle & (|(status_ff & wake_ff));
		nxt_st       = st_ff;
		nxt_valid    = valid_ff;
		nxt_level    = level_ff;
		nxt_addr     = addr_ff;
		case (st_ff)
			TLEC_ST_IDLE: begin
				if (cand_any && (!cur_any || (cand_idx < cur_idx))) begin
					nxt_st    = TLEC_ST_OFFER;
					nxt_valid = 1'b1;
					nxt_level = cand_idx;
					nxt_addr  = vec_mem_ff[cand_idx];
				end
			end
			TLEC_ST_OFFER: begin
				if (i_vec_accept) begin
					nxt_st    = TLEC_ST_IDLE;
					nxt_valid = 1'b0;
				end
			end
			default: begin
				nxt_st    = TLEC_ST_IDLE;
				nxt_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			latch_ff    <= '0;
			pend_ff     <= '0;
			st_ff       <= TLEC_ST_IDLE;
			valid_ff    <= 1'b0;
			level_ff    <= '0;
			addr_ff     <= '0;
			wake_out_ff <= 1'b0;
		end else begin
			latch_ff    <= nxt_latch;
			pend_ff     <= nxt_pend;
			st_ff       <= nxt_st;
			valid_ff    <= nxt_valid;
			level_ff    <= nxt_level;
			addr_ff     <= nxt_addr;
			wake_out_ff <= nxt_wake_out;
		end
	end

	assign o_prdata    = prdata_ff;
	assign o_pready    = pready_ff;
	assign o_pslverr   = slverr_ff;
	assign o_wakeup    = wake_out_ff;
	assign o_vec_valid = valid_ff;
	assign o_vec_level = level_ff;
	assign o_vec_addr  = addr_ff;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	take_sets_pend_a: assert property (take |=> pend_ff[$past(level_ff)])
		else $error("taken vector did not set its pending bit");
	take_clr_latch_a: assert property (take |=> !latch_ff[$past(level_ff)])
		else $error("taken vector left its latch bit set");
	return_clear_a: assert property ((i_return_from_interrupt && cur_any && !take)
		|=> !pend_ff[$past(cur_idx)])
		else $error("return did not clear the level in service");
	preempt_only_a: assert property (o_vec_valid |-> (!cur_any || (o_vec_level < cur_idx)))
		else $error("vector offered without outranking the level in service");
	mask_gate_a: assert property ($rose(o_vec_valid) |-> eff_mask[o_vec_level])
		else $error("vector offered for a masked level");
	vector_lookup_a: assert property (($rose(o_vec_valid) && !$past(vec_wr))
		|-> (o_vec_addr == vec_mem_ff[o_vec_level]))
		else $error("vector address does not match the table");
	gp_latch_a: assert property ((req_vec[7] && !pend_ff[7] && !take_vec[7]) |=> latch_ff[7])
		else $error("general-purpose request not latched");
	direct_entry_a: assert property ((nmi_s && !pend_ff[2] && !take_vec[2]) |=> latch_ff[2])
		else $error("nonmaskable request not latched directly");
	reset_mask_a: assert property ($rose(i_rst_n) |-> ((smask_ff == '0) && (asg_ff == ASG_RST)))
		else $error("system mask or mapping wrong after reset");
	wake_path_a: assert property ((i_core_idle && (|(status_ff & wake_ff))) |=> o_wakeup)
		else $error("enabled request did not wake the idle core");
	unmapped_err_a: assert property ((acc && !pready_ff && !hit) |=> (o_pready && o_pslverr))
		else $error("unmapped access not answered with an error");
endmodule

// *** testbench/tlec_core_model.sv ***
`timescale 1ns/100ps
// stands in for the instruction sequencer: takes each offered vector after a
// programmable number of cycles, so both prompt and slow pipelines are seen
module tlec_core_model (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_vec_valid,
	input  wire logic [1:0] i_delay,
	output logic            o_vec_accept
);
	logic [1:0] wait_ff;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_vec_accept <= 1'b0;
			wait_ff      <= 2'h0;
		end else if (o_vec_accept) begin
			// valid is sampled high with accept at this edge, so the take is done
			o_vec_accept <= 1'b0;
			wait_ff      <= 2'h0;
		end else if (i_vec_valid) begin
			if (wait_ff == i_delay) begin
				o_vec_accept <= 1'b1;
			end else begin
				wait_ff <= wait_ff + 2'h1;
			end
		end
	end
endmodule

// *** testbench/tb_tlec_top.sv ***
`timescale 1ns/100ps
`include "tlec_regs.svh"
module tb_tlec_top;
	logic        i_mclk, i_rst_n, psel, penable, pwrite, idle, ret_p, accept;
	logic [11:0] paddr;
	logic [31:0] pwdata, o_prdata, preq, seed, vt [16];
	logic        o_pready, o_pslverr, o_wakeup, o_vec_valid;
	logic [3:0]  o_vec_level, lv;
	logic [31:0] o_vec_addr;
	logic [5:0]  ded;
	logic [1:0]  delay;
	logic [35:0] exp_rd [$];
	logic [35:0] exp_vec [$];
	int          num_errors, checked, cyc, i, s, v;

	tlec_top u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_periph_req(preq),
		.i_emulation_req(ded[0]), .i_reset_event_req(ded[1]), .i_nonmaskable_req(ded[2]),
		.i_exception_req(ded[3]), .i_hardware_error_req(ded[4]), .i_core_timer_req(ded[5]),
		.i_core_idle(idle), .i_vec_accept(accept), .i_return_from_interrupt(ret_p),
		.o_wakeup(o_wakeup), .o_vec_valid(o_vec_valid), .o_vec_level(o_vec_level),
		.o_vec_addr(o_vec_addr));
	tlec_core_model u_core (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vec_valid(o_vec_valid),
		.i_delay(delay), .o_vec_accept(accept));

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		do @(posedge i_mclk); while (o_pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_rd.push_back({3'b000, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic ret();
		ret_p <= 1'b1;
		@(posedge i_mclk);
		ret_p <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic wait_q(input int n);
		while (exp_vec.size() > n) @(posedge i_mclk);
	endtask

	// results are matched in order against the notes left by the driver
	always @(posedge i_mclk) begin
		if (psel && penable && o_pready && !pwrite) begin
			if (exp_rd.size() > 0) chk({3'b000, o_pslverr, o_prdata}, exp_rd.pop_front());
			else chk({3'b000, o_pslverr, o_prdata}, 36'hF_FFFF_FFFF);
		end
		if (o_vec_valid && accept) begin
			if (exp_vec.size() > 0) chk({o_vec_level, o_vec_addr}, exp_vec.pop_front());
			else chk({o_vec_level, o_vec_addr}, 36'hF_FFFF_FFFF);
		end
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		{psel, penable, pwrite, idle, ret_p, paddr, pwdata, preq, ded} = '0;
		seed    = 32'h0000_029F;
		delay   = 2'h0;
		i_rst_n = 1'b0;
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		rd(`TLEC_OFF_SMASK, 33'h0_0000_0000);
		rd(`TLEC_OFF_WAKE, 33'h0_FFFF_FFFF);
		rd(`TLEC_OFF_ASSIGN0, 33'h0_0654_3210);
		rd(`TLEC_OFF_CMASK, 33'h0_0000_000F);
		rd(12'h0FC, 33'h1_0000_0000);
		apb(1'b1, `TLEC_OFF_CMASK, 32'h0000_FFE0);
		rd(`TLEC_OFF_CMASK, 33'h0_0000_FFEF);
		for (i = 0; i < 16; i++) begin
			vt[i] = rnd();
			apb(1'b1, `TLEC_OFF_VEC0 + 12'(4 * i), vt[i]);
		end
		$display("test registers done");
		// every dedicated event, each entering straight at the latch
		for (i = 0; i < 6; i++) begin
			lv = (i < 4) ? 4'(i) : 4'(i + 1);
			delay <= 2'(rnd());
			exp_vec.push_back({lv, vt[lv]});
			ded[i] <= 1'b1;
			wait_q(0);
			ded[i] <= 1'b0;
			repeat (6) @(posedge i_mclk);
			rd(`TLEC_OFF_PEND, {1'b0, 32'h1 << lv});
			ret();
			rd(`TLEC_OFF_PEND, 33'h0_0000_0000);
		end
		$display("test dedicated done");
		exp_vec.push_back({4'h3, vt[3]});
		exp_vec.push_back({4'h5, vt[5]});
		ded[3] <= 1'b1;
		ded[4] <= 1'b1;
		wait_q(1);
		ded[3] <= 1'b0;
		ded[4] <= 1'b0;
		repeat (6) @(posedge i_mclk);
		ret();
		wait_q(0);
		repeat (4) @(posedge i_mclk);
		ret();
		exp_vec.push_back({4'h6, vt[6]});
		ded[5] <= 1'b1;
		wait_q(0);
		ded[5] <= 1'b0;
		exp_vec.push_back({4'h2, vt[2]});
		ded[2] <= 1'b1;
		wait_q(0);
		ded[2] <= 1'b0;
		repeat (6) @(posedge i_mclk);
		rd(`TLEC_OFF_PEND, 33'h0_0000_0044);
		ret();
		rd(`TLEC_OFF_PEND, 33'h0_0000_0040);
		ret();
		// software levels: a raise below level seven is ignored, level fourteen is served
		apb(1'b1, `TLEC_OFF_RAISE, 32'h0000_0005);
		exp_vec.push_back({4'hE, vt[14]});
		apb(1'b1, `TLEC_OFF_RAISE, 32'h0000_000E);
		wait_q(0);
		repeat (2) @(posedge i_mclk);
		ret();
		rd(`TLEC_OFF_LATCH, 33'h0_0000_0000);
		rd(`TLEC_OFF_PEND, 33'h0_0000_0000);
		$display("test nesting done");
		s  = int'(rnd() % 32);
		v  = int'(rnd() % 9);
		lv = 4'(7 + v);
		apb(1'b1, `TLEC_OFF_ASSIGN0 + 12'(4 * (s / 8)), 32'(v) << (4 * (s % 8)));
		rd(`TLEC_OFF_ASSIGN0 + 12'(4 * (s / 8)), {1'b0, 32'(v) << (4 * (s % 8))});
		apb(1'b1, `TLEC_OFF_CMASK, 32'h0000_FFE0 & ~(32'h1 << lv));
		preq[s] <= 1'b1;
		repeat (12) @(posedge i_mclk);
		rd(`TLEC_OFF_STATUS, {1'b0, 32'h1 << s});
		rd(`TLEC_OFF_LATCH, 33'h0_0000_0000);
		apb(1'b1, `TLEC_OFF_SMASK, 32'h1 << s);
		repeat (6) @(posedge i_mclk);
		rd(`TLEC_OFF_LATCH, {1'b0, 32'h1 << lv});
		idle <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk({35'h0, o_wakeup}, 36'h0_0000_0001);
		apb(1'b1, `TLEC_OFF_WAKE, ~(32'h1 << s));
		repeat (2) @(posedge i_mclk);
		chk({35'h0, o_wakeup}, 36'h0_0000_0000);
		idle <= 1'b0;
		exp_vec.push_back({lv, vt[lv]});
		apb(1'b1, `TLEC_OFF_CMASK, 32'h0000_FFE0);
		wait_q(0);
		repeat (2) @(posedge i_mclk);
		rd(`TLEC_OFF_LATCH, 33'h0_0000_0000);
		rd(`TLEC_OFF_PEND, {1'b0, 32'h1 << lv});
		// the request is still asserted, so it latches again after return: keep it unoffered
		apb(1'b1, `TLEC_OFF_CMASK, 32'h0000_FFE0 & ~(32'h1 << lv));
		ret();
		rd(`TLEC_OFF_PEND, 33'h0_0000_0000);
		rd(`TLEC_OFF_STATUS, {1'b0, 32'h1 << s});
		rd(`TLEC_OFF_LATCH, {1'b0, 32'h1 << lv});
		preq[s] <= 1'b0;
		apb(1'b1, `TLEC_OFF_STATUS, 32'hFFFF_FFFF);
		repeat (8) @(posedge i_mclk);
		rd(`TLEC_OFF_STATUS, 33'h0_0000_0000);
		$display("test peripheral done");
		stop_test();
	end
endmodule
